// >>> rtl/ssed_defines.vh
// constants for the signal strength and energy detect readout
`ifndef SSED_DEFINES_VH
`define SSED_DEFINES_VH

// clock rate in MHz, used to turn microseconds into cycles
`define SSED_CLK_MHZ 50

// register indices, byte address is four times the index
`define SSED_IDX_STRENGTH 6'h06
`define SSED_IDX_ENERGY 6'h07
`define SSED_IDX_CTRL 6'h10
`define SSED_IDX_IRQ_STAT 6'h11
`define SSED_IDX_IRQ_MASK 6'h12

// reset values
`define SSED_ENERGY_RST 8'hFF
`define SSED_CTRL_RST 2'h0
`define SSED_MASK_RST 2'h0

// control field positions
`define SSED_CTRL_MODE_LO 0
`define SSED_CTRL_MODE_HI 1
`define SSED_CTRL_HIGH_RATE 2
`define SSED_CTRL_PDT_DIS 3
`define SSED_CTRL_BUSY 7

// interrupt status bit positions
`define SSED_IRQ_DONE 0
`define SSED_IRQ_SYNC 1

// modulation modes
`define SSED_MODE_BPSK20 2'd0
`define SSED_MODE_BPSK40 2'd1
`define SSED_MODE_OQPSK 2'd2

// receiver states seen on i_rx_state
`define SSED_RX_OFF 2'd0
`define SSED_RX_LISTEN 2'd1
`define SSED_RX_BUSY 2'd2
`define SSED_AUTO_ACK_RECEIVE_STATE 2'd3

// strength refresh periods
`define SSED_STR_BPSK20_US 32
`define SSED_STR_BPSK40_US 24
`define SSED_STR_OQPSK_US 8
`define SSED_STR_BPSK20_CYC (`SSED_STR_BPSK20_US * `SSED_CLK_MHZ)
`define SSED_STR_BPSK40_CYC (`SSED_STR_BPSK40_US * `SSED_CLK_MHZ)
`define SSED_STR_OQPSK_CYC (`SSED_STR_OQPSK_US * `SSED_CLK_MHZ)

// symbol periods and averaging windows
`define SSED_SYM_BPSK20_US 50
`define SSED_SYM_BPSK40_US 25
`define SSED_SYM_OQPSK_US 16
`define SSED_WIN_STD_SYMS 8
`define SSED_WIN_HDR_SYMS 2
`define SSED_SAMPLES 5'd16

// processing time after the window
`define SSED_PROC_US 12
`define SSED_PROC_CYC (`SSED_PROC_US * `SSED_CLK_MHZ)

// value limits
`define SSED_STRENGTH_MAX 5'd28
`define SSED_ENERGY_MAX 8'h54

`endif

// >>> rtl/ssed_energy_detect.v
// signal strength sampling and energy detection with apb registers
//
// What this block does
// - refresh strength every 32, 24 or 8 us by mode in receive states
// - strength is an unsigned 5-bit value limited to 0..28
// - strength saturates at 0 and at 28
// - each new strength sample lands in bits 4:0 of the strength register
// - a write to the energy register in listen or busy only triggers a measurement
// - sync detection starts an automatic measurement and sets the sync interrupt, never the done interrupt
// - manual measurement in listen or busy: 8 symbols, store, done interrupt
// - automatic result ready 8 symbols plus 12 us after frame start
// - high rate mode averages over 2 symbols plus 12 us
// - energy result held until the next measurement result
// - energy result stays within 0x00..0x54, 0xff only after reset
// - zero means floor power, top code means floor plus 84 dB
// - manual trigger outside plain receive states gives done without measuring
// - energy register reads 0xff after reset
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "ssed_defines.vh"

module ssed_energy_detect #(
   parameter P_SYM_BPSK20_CYC = `SSED_SYM_BPSK20_US * `SSED_CLK_MHZ,
   parameter P_SYM_BPSK40_CYC = `SSED_SYM_BPSK40_US * `SSED_CLK_MHZ,
   parameter P_SYM_OQPSK_CYC = `SSED_SYM_OQPSK_US * `SSED_CLK_MHZ
)
(
   // clock and reset
   input wire i_clk_sys,
   input wire i_sys_rst,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // receiver front end
   input wire [4:0] i_strength_raw,
   input wire i_sync_detect,
   input wire [1:0] i_rx_state,
   // interrupt
   output reg o_irq
);

   localparam ST_IDLE = 2'd0;
   localparam ST_MEAS = 2'd1;
   localparam ST_PROC = 2'd2;

   // front end synchronisers
   reg [4:0] raw_meta;
   reg [4:0] raw_sync;
   reg sync_meta;
   reg sync_sync;
   reg sync_prev;

   // register contents
   reg [4:0] strength;
   reg [7:0] energy_level_value;
   reg [1:0] mode;
   reg high_rate;
   reg preamble_detect_disable;
   reg [1:0] irq_stat;
   reg [1:0] irq_mask;

   // measurement engine
   reg [1:0] st;
   reg manual_run;
   reg [10:0] str_cnt;
   reg [15:0] slot_cnt;
   reg [4:0] samp_cnt;
   reg [8:0] acc;
   reg [9:0] proc_cnt;

   wire [5:0] idx;
   wire setup;
   wire wr_acc;
   wire in_rx_plain;
   wire in_rx_any;
   wire sync_evt;
   wire manual_trig;
   wire start_meas;
   wire manual_void;
   wire str_tick;
   wire slot_tick;
   wire meas_end;
   wire done_evt;
   wire [1:0] irq_set;
   wire [1:0] irq_clr;
   wire [31:0] proc_load;
   reg [31:0] rd_val;
   reg rd_hit;

   // refresh period in cycles for each modulation mode
   function [10:0] str_period;
      input [1:0] m;
      reg [31:0] cyc;
      begin
         case (m)
            `SSED_MODE_BPSK20: cyc = `SSED_STR_BPSK20_CYC;
            `SSED_MODE_BPSK40: cyc = `SSED_STR_BPSK40_CYC;
            default: cyc = `SSED_STR_OQPSK_CYC;
         endcase
         // longest period is 1600 cycles, so 11 bits always hold it
         str_period = cyc[10:0];
      end
   endfunction

   // one sixteenth of the averaging window, so 16 samples span it
   function [15:0] slot_len;
      input [1:0] m;
      input hr;
      reg [31:0] sym;
      reg [31:0] win;
      begin
         sym = P_SYM_OQPSK_CYC;
         if (m == `SSED_MODE_BPSK20)
         begin
            sym = P_SYM_BPSK20_CYC;
         end
         else if (m == `SSED_MODE_BPSK40)
         begin
            sym = P_SYM_BPSK40_CYC;
         end
         if (hr)
         begin
            win = sym * `SSED_WIN_HDR_SYMS;
         end
         else
         begin
            win = sym * `SSED_WIN_STD_SYMS;
         end
         slot_len = win[19:4];
      end
   endfunction

   // clamp a front end reading into the documented range
   function [4:0] sat_strength;
      input [4:0] r;
      begin
         if (r > `SSED_STRENGTH_MAX)
         begin
            sat_strength = `SSED_STRENGTH_MAX;
         end
         else
         begin
            sat_strength = r;
         end
      end
   endfunction

   // mean of 16 strength steps of ~3 dB turned into ~1 dB steps
   function [7:0] energy_code;
      input [8:0] sum;
      reg [10:0] scaled;
      begin
         scaled = {2'b00, sum} * 11'd3;
         energy_code = {1'b0, scaled[10:4]};
         if (energy_code > `SSED_ENERGY_MAX)
         begin
            energy_code = `SSED_ENERGY_MAX;
         end
      end
   endfunction

   assign idx = i_paddr[7:2];
   assign setup = i_psel & ~i_penable;
   assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;

   assign in_rx_plain = (i_rx_state == `SSED_RX_LISTEN) | (i_rx_state == `SSED_RX_BUSY);
   assign in_rx_any = in_rx_plain | (i_rx_state == `SSED_AUTO_ACK_RECEIVE_STATE);

   // sync detection is ignored while software holds it off
   assign sync_evt = sync_sync & ~sync_prev & in_rx_any & ~preamble_detect_disable;

   assign manual_trig = wr_acc & (idx == `SSED_IDX_ENERGY);
   assign start_meas = (manual_trig & in_rx_plain) | sync_evt;
   assign manual_void = manual_trig & ~in_rx_plain;

   assign str_tick = (str_cnt == 11'd0) & in_rx_any;
   assign slot_tick = (st == ST_MEAS) & (slot_cnt == 16'd0);
   assign meas_end = (st == ST_PROC) & (proc_cnt == 10'd0);

   // only manual runs announce their end
   assign done_evt = (meas_end & manual_run) | manual_void;
   assign irq_set = {sync_evt, done_evt};
   assign irq_clr = (wr_acc & (idx == `SSED_IDX_IRQ_STAT)) ? i_pwdata[1:0] : 2'b00;
   assign proc_load = `SSED_PROC_CYC - 1;

   // the raw bus is resynchronised bit by bit; the front end must hold it
   // steady for several cycles around each change to avoid a mixed sample
   always @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         raw_meta <= 5'd0;
         raw_sync <= 5'd0;
         sync_meta <= 1'b0;
         sync_sync <= 1'b0;
         sync_prev <= 1'b0;
      end
      else
      begin
         raw_meta <= i_strength_raw;
         raw_sync <= raw_meta;
         sync_meta <= i_sync_detect;
         sync_sync <= sync_meta;
         sync_prev <= sync_sync;
      end
   end

   // periodic strength refresh
   always @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         str_cnt <= 11'd0;
         strength <= 5'd0;
      end
      else if (!in_rx_any)
      begin
         str_cnt <= 11'd0;
      end
      else if (str_tick)
      begin
         str_cnt <= str_period(mode) - 11'd1;
         strength <= sat_strength(raw_sync);
      end
      else
      begin
         str_cnt <= str_cnt - 11'd1;
      end
   end

   // energy measurement engine
   always @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         st <= ST_IDLE;
         manual_run <= 1'b0;
         slot_cnt <= 16'd0;
         samp_cnt <= 5'd0;
         acc <= 9'd0;
         proc_cnt <= 10'd0;
         energy_level_value <= `SSED_ENERGY_RST;
      end
      else if (start_meas)
      begin
         // a retrigger throws away the partial sum and starts over
         st <= ST_MEAS;
         manual_run <= manual_trig;
         slot_cnt <= slot_len(mode, high_rate) - 16'd1;
         samp_cnt <= 5'd0;
         acc <= 9'd0;
      end
      else
      begin
         case (st)
            ST_IDLE:
            begin
               manual_run <= 1'b0;
            end
            ST_MEAS:
            begin
               if (slot_tick)
               begin
                  acc <= acc + {4'd0, strength};
                  samp_cnt <= samp_cnt + 5'd1;
                  slot_cnt <= slot_len(mode, high_rate) - 16'd1;
                  if (samp_cnt == `SSED_SAMPLES - 5'd1)
                  begin
                     st <= ST_PROC;
                     proc_cnt <= proc_load[9:0];
                  end
               end
               else
               begin
                  slot_cnt <= slot_cnt - 16'd1;
               end
            end
            ST_PROC:
            begin
               if (meas_end)
               begin
                  st <= ST_IDLE;
                  energy_level_value <= energy_code(acc);
               end
               else
               begin
                  proc_cnt <= proc_cnt - 10'd1;
               end
            end
            default:
            begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // control, mask and sticky status registers
   always @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         mode <= `SSED_CTRL_RST;
         high_rate <= 1'b0;
         preamble_detect_disable <= 1'b0;
         irq_mask <= `SSED_MASK_RST;
         irq_stat <= 2'b00;
      end
      else
      begin
         if (wr_acc && idx == `SSED_IDX_CTRL)
         begin
            mode <= i_pwdata[`SSED_CTRL_MODE_HI:`SSED_CTRL_MODE_LO];
            high_rate <= i_pwdata[`SSED_CTRL_HIGH_RATE];
            preamble_detect_disable <= i_pwdata[`SSED_CTRL_PDT_DIS];
         end
         if (wr_acc && idx == `SSED_IDX_IRQ_MASK)
         begin
            irq_mask <= i_pwdata[1:0];
         end
         // a new event outranks a clear in the same cycle
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   // read mux, registered during the setup cycle
   always @*
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (idx)
         `SSED_IDX_STRENGTH: rd_val = {27'd0, strength};
         `SSED_IDX_ENERGY: rd_val = {24'd0, energy_level_value};
         `SSED_IDX_CTRL:
         begin
            rd_val[`SSED_CTRL_MODE_HI:`SSED_CTRL_MODE_LO] = mode;
            rd_val[`SSED_CTRL_HIGH_RATE] = high_rate;
            rd_val[`SSED_CTRL_PDT_DIS] = preamble_detect_disable;
            rd_val[`SSED_CTRL_BUSY] = (st != ST_IDLE);
         end
         `SSED_IDX_IRQ_STAT: rd_val = {30'd0, irq_stat};
         `SSED_IDX_IRQ_MASK: rd_val = {30'd0, irq_mask};
         default: rd_hit = 1'b0;
      endcase
   end

   // one wait-free access cycle; data and error are flops from setup
   always @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         o_prdata <= 32'h0000_0000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_irq <= 1'b0;
      end
      else
      begin
         o_pready <= setup;
         o_pslverr <= setup & ~rd_hit;
         if (setup && !i_pwrite)
         begin
            o_prdata <= rd_val;
         end
         o_irq <= |(irq_stat & irq_mask);
      end
   end

endmodule

// >>> verification/ssed_energy_detect_checker.sv
// assertion checker for the energy detect block
`timescale 1ns/1ps
`include "ssed_defines.vh"
module ssed_chk (
   // clock and reset
   input wire i_clk_sys,
   input wire i_sys_rst,
   // apb
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [31:0] o_prdata,
   input wire o_pready,
   input wire o_pslverr,
   // receiver and interrupt
   input wire [1:0] i_rx_state,
   input wire o_irq
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   reg [1:0] mask;
   wire [5:0] ix = i_paddr[7:2];
   wire acc = i_psel && i_penable && o_pready;
   wire rd = acc && !i_pwrite;
   wire wr_ed = acc && i_pwrite && ix == `SSED_IDX_ENERGY;
   // mirror of the mask so the level output can be judged
   always @(posedge i_clk_sys)
      if (i_sys_rst)
         mask <= 2'h0;
      else if (acc && i_pwrite && ix == `SSED_IDX_IRQ_MASK)
         mask <= i_pwdata[1:0];
   sequence s_idle_trig;
      wr_ed && mask[0] && (i_rx_state == 2'd0 || i_rx_state == 2'd3);
   endsequence
   sequence s_done;
      ##[1:4] o_irq;
   endsequence
   AST_RDY: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no answer after setup");
   AST_RDY1: assert property (o_pready |=> !o_pready)
      else $error("ready held too long");
   AST_ERR: assert property (rd && ix > `SSED_IDX_IRQ_MASK |-> o_pslverr && o_prdata == 0)
      else $error("unmapped read not refused");
   AST_ED_RANGE: assert property (rd && ix == `SSED_IDX_ENERGY |->
      o_prdata[31:8] == 0 && (o_prdata[7:0] <= 8'h54 || o_prdata[7:0] == 8'hff))
      else $error("energy code out of range");
   AST_STR: assert property (rd && ix == `SSED_IDX_STRENGTH |-> o_prdata[31:5] == 0 && o_prdata[4:0] <= 5'h1c)
      else $error("strength out of range");
   AST_NOMEAS: assert property (s_idle_trig |-> s_done)
      else $error("no done outside receive");
   AST_WAIT: assert property (wr_ed && i_rx_state[0] != i_rx_state[1] && !o_irq |=> !o_irq [*8])
      else $error("done came without measuring");
   AST_MASK: assert property (mask == 0 && $past(mask) == 0 |-> !o_irq)
      else $error("irq while masked");
endmodule
bind ssed_energy_detect ssed_chk ssed_chk_i (.i_clk_sys, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_state, .o_irq);

// >>> verification/ssed_energy_detect_tb_top.sv
// self-checking bench for the energy detect block
`timescale 1ns/1ps
`include "ssed_defines.vh"
module ssed_energy_detect_tb_top;
   localparam SYM = 32;
   reg i_clk_sys = 1'b0;
   reg i_sys_rst = 1'b1;
   reg psel = 1'b0;
   reg pen = 1'b0;
   reg pwr = 1'b0;
   reg hdr = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0000_0000;
   reg [1:0] rx = 2'h0;
   reg [4:0] lvl = 5'h00;
   reg [4:0] l;
   reg [7:0] ed = 8'hff;
   reg [31:0] seed = 32'hdffe_0da2;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire irq;
   wire sync;
   wire [4:0] raw;
   int err_count = 0;
   int num_checks = 0;
   int p;
   logic [32:0] q[$];

   initial forever #10 i_clk_sys = ~i_clk_sys;

   ssed_energy_detect #(.P_SYM_BPSK20_CYC(SYM), .P_SYM_BPSK40_CYC(SYM), .P_SYM_OQPSK_CYC(SYM))
   ssed_energy_detect_i (.i_clk_sys, .i_sys_rst, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_strength_raw(raw), .i_sync_detect(sync), .i_rx_state(rx), .o_irq(irq));
   ssed_front_end ssed_front_end_i (.i_clk_sys, .i_level(lvl), .i_hdr(hdr), .o_strength_raw(raw),
      .o_sync_detect(sync));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // saturating strength expectation
   function automatic logic [7:0] cl(input logic [4:0] v);
      return v > 5'h1c ? 8'h1c : {3'h0, v};
   endfunction
   task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
      num_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("wrong value %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [5:0] ix, input logic [31:0] d);
      int n;
      @(posedge i_clk_sys);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {ix, 2'h0};
      pwdata <= d;
      @(posedge i_clk_sys);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         err_count++;
         end_sim();
      end
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] ix, input logic [32:0] e);
      q.push_back(e);
      apb(1'b0, ix, 32'h0000_0000);
   endtask
   task automatic wirq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim)
      begin
         @(posedge i_clk_sys);
         n++;
      end
      chk("irq", irq, 1);
      if (n == lim)
         end_sim();
   endtask
   // restarting receive forces a strength refresh at a known edge
   task automatic prime(input logic [4:0] v);
      lvl <= v;
      rx <= 2'h0;
      repeat (6) @(posedge i_clk_sys);
      rx <= 2'h1;
      repeat (4) @(posedge i_clk_sys);
   endtask
   task automatic pulse(input int n);
      hdr <= 1'b1;
      @(posedge i_clk_sys);
      hdr <= 1'b0;
      repeat (n) @(posedge i_clk_sys);
   endtask

   always @(posedge i_clk_sys)
      if (psel && pen && pready === 1'b1 && !pwr)
         chk("rd", {pslverr, prdata}, q.pop_front());

   initial
   begin
      repeat (6) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      rd(`SSED_IDX_ENERGY, ed);
      apb(1'b1, `SSED_IDX_STRENGTH, 32'h0000_001f);
      rd(`SSED_IDX_STRENGTH, 0);
      rd(6'h3f, 33'h1_0000_0000);
      $display("test reset end");
      // mode 3 must behave like the fastest mode
      for (int m = 0; m < 4; m++)
      begin
         p = m == 0 ? 1600 : m == 1 ? 1200 : 400;
         l = 5'(rnd());
         apb(1'b1, `SSED_IDX_CTRL, m);
         prime(l);
         lvl <= ~l;
         repeat (p - 60) @(posedge i_clk_sys);
         rd(`SSED_IDX_STRENGTH, cl(l));
         repeat (80) @(posedge i_clk_sys);
         rd(`SSED_IDX_STRENGTH, cl(~l));
      end
      $display("test strength end");
      apb(1'b1, `SSED_IDX_IRQ_MASK, 32'h0000_0001);
      for (int h = 0; h < 2; h++)
      begin
         l = h ? 5'h1f : 5'(rnd());
         apb(1'b1, `SSED_IDX_CTRL, h ? 32'h0000_0006 : 32'h0000_0002);
         prime(l);
         // listen first, then busy receive
         rx <= 2'(h + 1);
         apb(1'b1, `SSED_IDX_ENERGY, rnd());
         rd(`SSED_IDX_ENERGY, ed);
         rd(`SSED_IDX_CTRL, h ? 32'h0000_0086 : 32'h0000_0082);
         repeat (h ? 650 : 842) @(posedge i_clk_sys);
         chk("irq", irq, 0);
         wirq(30);
         ed = cl(l) * 8'h03;
         rd(`SSED_IDX_ENERGY, ed);
         rd(`SSED_IDX_IRQ_STAT, 1);
         apb(1'b1, `SSED_IDX_IRQ_STAT, 32'h0000_0001);
         repeat (2) @(posedge i_clk_sys);
         chk("irq", irq, 0);
      end
      apb(1'b1, `SSED_IDX_ENERGY, 32'h0000_0000);
      repeat (300) @(posedge i_clk_sys);
      apb(1'b1, `SSED_IDX_ENERGY, 32'h0000_0000);
      repeat (650) @(posedge i_clk_sys);
      chk("irq", irq, 0);
      wirq(30);
      apb(1'b1, `SSED_IDX_IRQ_STAT, 32'h0000_0001);
      repeat (700) @(posedge i_clk_sys);
      chk("irq", irq, 0);
      $display("test manual end");
      for (int s = 0; s < 4; s += 3)
      begin
         rx <= 2'(s);
         apb(1'b1, `SSED_IDX_ENERGY, 32'h0000_0000);
         wirq(6);
         rd(`SSED_IDX_ENERGY, ed);
         rd(`SSED_IDX_CTRL, 32'h0000_0006);
         apb(1'b1, `SSED_IDX_IRQ_STAT, 32'h0000_0001);
      end
      apb(1'b1, `SSED_IDX_IRQ_MASK, 32'h0000_0000);
      apb(1'b1, `SSED_IDX_ENERGY, 32'h0000_0000);
      repeat (5) @(posedge i_clk_sys);
      chk("irq", irq, 0);
      apb(1'b1, `SSED_IDX_IRQ_MASK, 32'h0000_0001);
      wirq(6);
      apb(1'b1, `SSED_IDX_IRQ_STAT, 32'h0000_0001);
      $display("test idle end");
      l = 5'(rnd());
      prime(l);
      pulse(624);
      rd(`SSED_IDX_ENERGY, ed);
      repeat (50) @(posedge i_clk_sys);
      ed = cl(l) * 8'h03;
      rd(`SSED_IDX_ENERGY, ed);
      chk("irq", irq, 0);
      rd(`SSED_IDX_IRQ_STAT, 2);
      apb(1'b1, `SSED_IDX_IRQ_STAT, 32'h0000_0003);
      lvl <= ~l;
      repeat (1000) @(posedge i_clk_sys);
      rd(`SSED_IDX_ENERGY, ed);
      apb(1'b1, `SSED_IDX_CTRL, 32'h0000_000e);
      pulse(800);
      rd(`SSED_IDX_ENERGY, ed);
      $display("test auto end");
      end_sim();
   end
endmodule

// >>> verification/ssed_front_end.sv
// receiver front end model: strength level and sync header pulses
`timescale 1ns/1ps
module ssed_front_end (
   // from the bench
   input wire i_clk_sys,
   input wire [4:0] i_level,
   input wire i_hdr,
   // to the block
   output reg [4:0] o_strength_raw = 5'h00,
   output reg o_sync_detect = 1'b0
);
   reg [2:0] cnt = 3'h0;
   // pulse held several cycles so the two sync flops cannot miss it
   always @(posedge i_clk_sys)
   begin
      o_strength_raw <= i_level;
      cnt <= i_hdr ? 3'h6 : cnt - (cnt != 3'h0);
      o_sync_detect <= i_hdr || cnt != 3'h0;
   end
endmodule
